/* File: rtl/dlpsc_device.sv */
// memory-device end: power-down and deep sleep tracking; a parked clock leaves the state as it was.
// assumes: clocked by the link true clock; status is read on ref_clk.
`default_nettype none
module dlpsc_device (
  dlpsc_link_if.device link, // link pins from the controller
  input wire logic ref_clk, // status-side clock
  input wire logic rst_n, // synchronous reset, active low
  output logic [2:0] dev_state, // state seen on ref_clk
  output logic rx_enabled, // receivers on, ref_clk domain
  output logic mode_valid, // mode registers hold values
  output logic access_done // pulse on ref_clk per executed access
);
  // ==========================================================
  // link-clock domain, fed by a reset stretcher on ref_clk
  dlpsc_pkg::dlpsc_state_t st_reg, st_next;
  logic [dlpsc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic mode_reg, mode_next;
  logic acc_tgl_reg, acc_tgl_next;
  logic link_rst_reg;
  logic [1:0] lrs_reg;
  logic [3:0] hold_reg, hold_next;
  logic hold_done_reg;
  // the link clock is frozen while rst_n is low, so reset is
  // stretched on ref_clk until the link has run for a few edges
  always_comb begin
    hold_next = (hold_reg == 4'hF) ? hold_reg : hold_reg + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_reg <= 4'h0;
      hold_done_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      hold_done_reg <= (hold_reg == 4'hF);
    end
  end
  // reset passes into link domain through three flops
  always_ff @(posedge link.clk_t) begin
    lrs_reg <= {lrs_reg[0], hold_done_reg};
    link_rst_reg <= lrs_reg[1];
  end
  logic is_access;
  assign is_access = (link.cmd == dlpsc_pkg::CMD_ACT) ||
    (link.cmd == dlpsc_pkg::CMD_PRE) ||
    (link.cmd == dlpsc_pkg::CMD_READ) ||
    (link.cmd == dlpsc_pkg::CMD_WRITE);
  logic exit_ok;
  assign exit_ok = link.clk_gate && ((link.cmd == dlpsc_pkg::CMD_IDLE) ||
    link.cmd[3]);
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    acc_tgl_next = acc_tgl_reg;
    case (st_reg)
      dlpsc_pkg::DLPS_IDLE, dlpsc_pkg::DLPS_ACTIVE: begin
        if (!link.clk_gate && link.cmd == dlpsc_pkg::CMD_BSTOP) begin
          st_next = dlpsc_pkg::DLPS_DEEP;
          mode_next = 1'b0;
        end else if (!link.clk_gate) begin
          st_next = link.bank_open ? dlpsc_pkg::DLPS_PD_ACT :
            dlpsc_pkg::DLPS_PD_PRE;
        end else begin
          if (is_access && mode_reg) begin
            acc_tgl_next = ~acc_tgl_reg;
          end
          // clock may park here at any edge
          if (link.cmd == dlpsc_pkg::CMD_ACT) begin
            st_next = dlpsc_pkg::DLPS_ACTIVE;
          end else if (link.cmd == dlpsc_pkg::CMD_PRE) begin
            st_next = dlpsc_pkg::DLPS_IDLE;
          end
        end
      end
      dlpsc_pkg::DLPS_PD_PRE, dlpsc_pkg::DLPS_PD_ACT: begin
        // exit needs the gate high and an idle or unselected command
        if (exit_ok) begin
          st_next = (st_reg == dlpsc_pkg::DLPS_PD_ACT) ?
            dlpsc_pkg::DLPS_ACTIVE : dlpsc_pkg::DLPS_IDLE;
        end
      end
      dlpsc_pkg::DLPS_DEEP: begin
        if (link.clk_gate) begin
          st_next = dlpsc_pkg::DLPS_DEEP_WAIT;
          cnt_next = '0;
        end
      end
      dlpsc_pkg::DLPS_DEEP_WAIT: begin
        // no access executes during the wait
        if (cnt_reg == dlpsc_pkg::CNT_W'(dlpsc_pkg::DEEP_WAIT_CYC - 1)) begin
          st_next = dlpsc_pkg::DLPS_UNINIT;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      dlpsc_pkg::DLPS_UNINIT: begin
        // a precharge stands for the reinit sequence finishing
        if (link.cmd == dlpsc_pkg::CMD_PRE) begin
          st_next = dlpsc_pkg::DLPS_IDLE;
          mode_next = 1'b1;
          acc_tgl_next = ~acc_tgl_reg;
        end
      end
      default: st_next = dlpsc_pkg::DLPS_IDLE;
    endcase
  end
  always_ff @(posedge link.clk_t) begin
    if (!link_rst_reg) begin
      st_reg <= dlpsc_pkg::DLPS_IDLE;
      cnt_reg <= '0;
      mode_reg <= 1'b1;
      acc_tgl_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
      acc_tgl_reg <= acc_tgl_next;
    end
  end
  // ==========================================================
  // ref_clk side: state is quasi-static, sampled by three flops
  logic [2:0] s1_reg, s2_reg, s3_reg, dst_reg, dst_next;
  logic m1_reg, m2_reg, m3_reg, mv_reg, mv_next;
  logic t1_reg, t2_reg, t3_reg, ad_reg, ad_next;
  always_comb begin
    dst_next = (s2_reg == s3_reg) ? s3_reg : dst_reg;
    mv_next = (m2_reg == m3_reg) ? m3_reg : mv_reg;
    ad_next = t2_reg ^ t3_reg;
  end
  always_ff @(posedge ref_clk) begin
    s1_reg <= st_reg;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    m1_reg <= mode_reg;
    m2_reg <= m1_reg;
    m3_reg <= m2_reg;
    t1_reg <= acc_tgl_reg;
    t2_reg <= t1_reg;
    t3_reg <= t2_reg;
    if (!rst_n) begin
      dst_reg <= 3'h0;
      mv_reg <= 1'b1;
      ad_reg <= 1'b0;
    end else begin
      dst_reg <= dst_next;
      mv_reg <= mv_next;
      ad_reg <= ad_next;
    end
  end
  assign dev_state = dst_reg;
  assign mode_valid = mv_reg;
  assign access_done = ad_reg;
  assign rx_enabled = (dst_reg == 3'h0) || (dst_reg == 3'h1) ||
    (dst_reg == 3'h6);
endmodule : dlpsc_device
`default_nettype wire

/* File: rtl/dlpsc_pkg.sv */
// package for the low-power state control pair: commands, states, timing.
// assumes: both ends and the link interface share these definitions.
`default_nettype none
package dlpsc_pkg;
  // ==========================================================
  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_IDLE = 4'h7;
  localparam logic [3:0] CMD_UNSEL = 4'h8;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_BSTOP = 4'h6;
  // ==========================================================
  // timing, link clock at 12.5 MHz (80 ns)
  localparam int LINK_PERIOD_NS = 80;
  localparam int REF_PERIOD_NS = 20;
  localparam int DEEP_WAIT_US = 200;
  localparam int DEEP_WAIT_CYC =
    (DEEP_WAIT_US * 1000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int MIN_GATE_LOW_CYC = 3;
  localparam int SLEEP_EXIT_CYC = 2;
  localparam int ACCESS_CYC = 4;
  localparam int DIV_HALF = 2;
  localparam int CNT_W = 16;
  typedef enum logic [2:0] {
    DLPS_IDLE = 3'h0,
    DLPS_ACTIVE = 3'h1,
    DLPS_PD_PRE = 3'h2,
    DLPS_PD_ACT = 3'h3,
    DLPS_DEEP = 3'h4,
    DLPS_DEEP_WAIT = 3'h5,
    DLPS_UNINIT = 3'h6
  } dlpsc_state_t;
  typedef enum logic [2:0] {
    DLPH_RUN = 3'h0,
    DLPH_PD = 3'h1,
    DLPH_PD_EXIT = 3'h2,
    DLPH_DEEP = 3'h3,
    DLPH_DEEP_EXIT = 3'h4,
    DLPH_STOP = 3'h5,
    DLPH_RESTART = 3'h6
  } dlpsc_hstate_t;
endpackage : dlpsc_pkg
`default_nettype wire

/* File: rtl/dlpsc_link_if.sv */
// link between controller and memory device: clock pair, gate, command.
// assumes: the controller end makes clk_t/clk_c from its own clock.
`default_nettype none
interface dlpsc_link_if;
  logic clk_t;
  logic clk_c;
  logic clk_gate;
  logic [3:0] cmd;
  logic bank_open;
  modport device (input clk_t, input clk_c, input clk_gate, input cmd,
    input bank_open);
  modport ctrl (output clk_t, output clk_c, output clk_gate, output cmd,
    output bank_open);
endinterface : dlpsc_link_if
`default_nettype wire

/* File: rtl/dlpsc_ctrl.sv */
// controller end: drives clock pair, gate and commands to the device.
// assumes: user requests are levels/pulses on ref_clk.
`default_nettype none
module dlpsc_ctrl #(
  parameter int DEEP_WAIT_CYC = dlpsc_pkg::DEEP_WAIT_CYC * 4
) (
  dlpsc_link_if.ctrl link, // link pins to the device
  input wire logic ref_clk, // 50 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic req_pd, // level: stay in power-down
  input wire logic req_deep, // pulse: enter deep sleep
  input wire logic req_wake, // pulse: leave deep sleep
  input wire logic req_stop, // level: park the clock
  input wire logic acc_valid, // access request
  input wire logic [3:0] acc_cmd, // access command
  output logic acc_ready, // access taken this cycle
  output logic [2:0] ctrl_state // controller state
);
  // ==========================================================
  // clock divider: link edge every DIV_HALF ref cycles
  dlpsc_pkg::dlpsc_hstate_t st_reg, st_next;
  logic [1:0] div_reg, div_next;
  logic ck_reg, ck_next;
  logic run_ck;
  logic [dlpsc_pkg::CNT_W+1:0] cnt_reg, cnt_next;
  logic gate_reg, gate_next, open_reg, open_next;
  logic [3:0] cmd_reg, cmd_next;
  logic rise;
  assign run_ck = (st_reg != dlpsc_pkg::DLPH_STOP);
  // launch on the falling link edge: half a period of setup
  assign rise = run_ck && ck_reg &&
    (div_reg == 2'(dlpsc_pkg::DIV_HALF - 1));
  assign acc_ready = rise && st_reg == dlpsc_pkg::DLPH_RUN && acc_valid &&
    !req_pd && !req_stop && cnt_reg == '0 && !(req_deep && !open_reg);
  always_comb begin
    div_next = div_reg;
    ck_next = ck_reg;
    st_next = st_reg;
    cnt_next = cnt_reg;
    gate_next = gate_reg;
    open_next = open_reg;
    cmd_next = cmd_reg;
    if (run_ck) begin
      if (div_reg == 2'(dlpsc_pkg::DIV_HALF - 1)) begin
        div_next = '0;
        ck_next = ~ck_reg;
      end else begin
        div_next = div_reg + 1'b1;
      end
    end else begin
      ck_next = 1'b0;
    end
    if (rise) begin
      cmd_next = dlpsc_pkg::CMD_IDLE;
      if (cnt_reg != '0) begin
        cnt_next = cnt_reg - 1'b1;
      end
      case (st_reg)
        dlpsc_pkg::DLPH_RUN: begin
          if (cnt_reg != '0) begin
            // finish pending delays first
          end else if (req_deep && !open_reg) begin
            gate_next = 1'b0;
            cmd_next = dlpsc_pkg::CMD_BSTOP;
            st_next = dlpsc_pkg::DLPH_DEEP;
          end else if (req_pd) begin
            gate_next = 1'b0;
            cnt_next = (dlpsc_pkg::CNT_W+2)'(dlpsc_pkg::MIN_GATE_LOW_CYC);
            st_next = dlpsc_pkg::DLPH_PD;
          end else if (acc_valid && !req_stop) begin
            cmd_next = acc_cmd;
            if (acc_cmd == dlpsc_pkg::CMD_ACT) open_next = 1'b1;
            if (acc_cmd == dlpsc_pkg::CMD_PRE) open_next = 1'b0;
            cnt_next = (dlpsc_pkg::CNT_W+2)'(dlpsc_pkg::ACCESS_CYC);
          end else if (req_stop) begin
            st_next = dlpsc_pkg::DLPH_STOP;
          end
        end
        dlpsc_pkg::DLPH_PD: begin
          if (!req_pd && cnt_reg == '0) begin
            gate_next = 1'b1;
            cnt_next = (dlpsc_pkg::CNT_W+2)'(dlpsc_pkg::SLEEP_EXIT_CYC);
            st_next = dlpsc_pkg::DLPH_PD_EXIT;
          end
        end
        dlpsc_pkg::DLPH_PD_EXIT: begin
          if (cnt_reg <= 1) st_next = dlpsc_pkg::DLPH_RUN;
        end
        dlpsc_pkg::DLPH_DEEP: begin
          if (req_wake) begin
            gate_next = 1'b1;
            cnt_next = (dlpsc_pkg::CNT_W+2)'(DEEP_WAIT_CYC);
            st_next = dlpsc_pkg::DLPH_DEEP_EXIT;
          end
        end
        dlpsc_pkg::DLPH_DEEP_EXIT: begin
          if (cnt_reg <= 1) begin
            cmd_next = dlpsc_pkg::CMD_PRE;
            st_next = dlpsc_pkg::DLPH_RUN;
          end
        end
        dlpsc_pkg::DLPH_RESTART: st_next = dlpsc_pkg::DLPH_RUN;
        default: st_next = dlpsc_pkg::DLPH_RUN;
      endcase
    end else if (st_reg == dlpsc_pkg::DLPH_STOP && !req_stop) begin
      st_next = dlpsc_pkg::DLPH_RESTART;
      div_next = '0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= dlpsc_pkg::DLPH_RUN;
      div_reg <= '0;
      ck_reg <= 1'b0;
      cnt_reg <= '0;
      gate_reg <= 1'b1;
      open_reg <= 1'b0;
      cmd_reg <= dlpsc_pkg::CMD_IDLE;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      ck_reg <= ck_next;
      cnt_reg <= cnt_next;
      gate_reg <= gate_next;
      open_reg <= open_next;
      cmd_reg <= cmd_next;
    end
  end
  assign link.clk_t = ck_reg;
  assign link.clk_c = ~ck_reg;
  assign link.clk_gate = gate_reg;
  assign link.cmd = cmd_reg;
  assign link.bank_open = open_reg;
  assign ctrl_state = st_reg;
endmodule : dlpsc_ctrl
`default_nettype wire

/* File: bench/dlpsc_link_sva.sv */
// link checker: clock pair, gate and command spacing.
// assumes: fed from the link interface, ref_clk and rst_n.
`default_nettype none
module dlpsc_link_sva (
  input wire logic ref_clk, // status clock
  input wire logic rst_n, // sync reset, low
  input wire logic clk_t, // true link clock
  input wire logic clk_c, // complement clock
  input wire logic clk_gate, // clock enable
  input wire logic [3:0] cmd, // command code
  input wire logic bank_open // row open
);
  // ====
  // helpers
  logic deep_reg;
  logic [3:0] low_reg;
  logic [3:0] acc_reg;
  wire quiet = cmd == dlpsc_pkg::CMD_IDLE || cmd[3];
  wire bstop_lo = !clk_gate && cmd == dlpsc_pkg::CMD_BSTOP;
  // deep flag kept on the link clock, as the device samples it
  always_ff @(posedge clk_t) begin
    if (!rst_n) deep_reg <= 1'b0;
    else if (bstop_lo) deep_reg <= 1'b1;
    else if (clk_gate) deep_reg <= 1'b0;
  end
  // normal low phase is two ref cycles, so three means parked
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clk_t) low_reg <= 4'h0;
    else if (low_reg != 4'hF) low_reg <= low_reg + 4'h1;
    if (!rst_n || !quiet) acc_reg <= 4'h0;
    else if (acc_reg != 4'hF) acc_reg <= acc_reg + 4'h1;
  end
  // ====
  // properties
  sequence s_quiet;
    quiet;
  endsequence
  sequence s_nops;
    (cmd == dlpsc_pkg::CMD_IDLE) [*8];
  endsequence
  property p_pair;
    @(posedge ref_clk) disable iff (!rst_n) clk_c == !clk_t;
  endproperty
  a_pair: assert property (p_pair) else $error("clock pair");
  property p_exit_cmd;
    @(posedge clk_t) disable iff (!rst_n) $rose(clk_gate) |-> s_quiet;
  endproperty
  a_exit_cmd: assert property (p_exit_cmd) else $error("exit cmd");
  property p_exit_gap;
    @(posedge clk_t) disable iff (!rst_n) $rose(clk_gate) |=> s_quiet;
  endproperty
  a_exit_gap: assert property (p_exit_gap) else $error("exit gap");
  property p_gate_min;
    @(posedge clk_t) disable iff (!rst_n) $fell(clk_gate) |=> !clk_gate [*2];
  endproperty
  a_gate_min: assert property (p_gate_min) else $error("gate min");
  property p_deep_hold;
    @(posedge clk_t) disable iff (!rst_n)
      bstop_lo && $fell(clk_gate) |=> !clk_gate [*8];
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("deep");
  property p_deep_wake;
    @(posedge clk_t) disable iff (!rst_n) $rose(clk_gate) && deep_reg |-> s_nops;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("wake");
  property p_deep_bank;
    @(posedge clk_t) disable iff (!rst_n) bstop_lo |-> !bank_open;
  endproperty
  a_deep_bank: assert property (p_deep_bank) else $error("bank");
  property p_stop_done;
    @(posedge ref_clk) disable iff (!rst_n)
      low_reg == 4'h3 && clk_gate |-> quiet && acc_reg >= 4'h8;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop");
endmodule : dlpsc_link_sva
`default_nettype wire

/* File: bench/tb_dram_low_power_state_control.sv */
// bench: controller and device joined by the link, one task a scenario.
// assumes: ctrl makes the link clock; its deep wait is shortened.
`default_nettype none
module tb_dram_low_power_state_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_pd = 1'b0;
  logic req_deep = 1'b0;
  logic req_wake = 1'b0;
  logic req_stop = 1'b0;
  logic acc_valid = 1'b0;
  logic [3:0] acc_cmd = dlpsc_pkg::CMD_IDLE;
  logic acc_ready;
  logic [2:0] ctrl_state;
  logic [2:0] dev_state;
  logic rx_enabled;
  logic mode_valid;
  logic access_done;
  int errors = 0;
  int comparisons = 0;
  dlpsc_link_if link ();
  dlpsc_ctrl #(.DEEP_WAIT_CYC(40)) dlpsc_ctrl_i (.link(link),
    .ref_clk(ref_clk), .rst_n(rst_n), .req_pd(req_pd), .req_deep(req_deep),
    .req_wake(req_wake), .req_stop(req_stop), .acc_valid(acc_valid),
    .acc_cmd(acc_cmd), .acc_ready(acc_ready), .ctrl_state(ctrl_state));
  dlpsc_device dlpsc_device_i (.link(link), .ref_clk(ref_clk), .rst_n(rst_n),
    .dev_state(dev_state), .rx_enabled(rx_enabled),
    .mode_valid(mode_valid), .access_done(access_done));
  dlpsc_link_sva dlpsc_link_sva_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_t(link.clk_t), .clk_c(link.clk_c), .clk_gate(link.clk_gate),
    .cmd(link.cmd), .bank_open(link.bank_open));
  always #10 ref_clk = ~ref_clk;
  // ====
  // shared tasks
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic check(string w, logic [2:0] e, logic [2:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : check
  task automatic wait_ctrl(logic [2:0] s);
    int n = 0;
    while (ctrl_state !== s && n < 200) begin
      cyc(1);
      n++;
    end
    check("ctrl_state", s, ctrl_state);
  endtask : wait_ctrl
  // accesses stay five link periods apart, so each ends after 24 cycles
  task automatic access(logic [3:0] c, logic [2:0] exp);
    int n = 0;
    acc_cmd = c;
    acc_valid = 1'b1;
    while (acc_ready !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    cyc(1);
    acc_valid = 1'b0;
    n = 0;
    repeat (24) begin
      cyc(1);
      n += (access_done === 1'b1);
    end
    check("access_done", exp, 3'(n));
  endtask : access
  // ====
  // scenarios
  task automatic t_access();
    access(dlpsc_pkg::CMD_ACT, 3'h1);
    check("dev_state", dlpsc_pkg::DLPS_ACTIVE, dev_state);
    access(dlpsc_pkg::CMD_READ, 3'h1);
    access(dlpsc_pkg::CMD_WRITE, 3'h1);
    access(dlpsc_pkg::CMD_PRE, 3'h1);
    check("dev_state", dlpsc_pkg::DLPS_IDLE, dev_state);
    $display("t_access finished");
  endtask : t_access
  task automatic t_pd(logic open);
    if (open) access(dlpsc_pkg::CMD_ACT, 3'h1);
    req_pd = 1'b1;
    cyc(40);
    check("pd", open ? dlpsc_pkg::DLPS_PD_ACT : dlpsc_pkg::DLPS_PD_PRE,
      dev_state);
    check("rx_enabled", 3'h0, 3'(rx_enabled));
    req_pd = 1'b0;
    cyc(20);
    check("exit", open ? dlpsc_pkg::DLPS_ACTIVE : dlpsc_pkg::DLPS_IDLE,
      dev_state);
    check("rx_enabled", 3'h1, 3'(rx_enabled));
    if (!open) access(dlpsc_pkg::CMD_ACT, 3'h1);
    access(dlpsc_pkg::CMD_PRE, 3'h1);
    $display("t_pd finished");
  endtask : t_pd
  task automatic t_deep();
    int n = 0;
    req_deep = 1'b1;
    wait_ctrl(dlpsc_pkg::DLPH_DEEP);
    req_deep = 1'b0;
    cyc(60);
    check("deep", dlpsc_pkg::DLPS_DEEP, dev_state);
    check("mode_valid", 3'h0, 3'(mode_valid));
    req_wake = 1'b1;
    wait_ctrl(dlpsc_pkg::DLPH_DEEP_EXIT);
    req_wake = 1'b0;
    wait_ctrl(dlpsc_pkg::DLPH_RUN);
    check("wait", dlpsc_pkg::DLPS_DEEP_WAIT, dev_state);
    access(dlpsc_pkg::CMD_ACT, 3'h0);
    // device wait is 2500 link periods, not shortened
    while (dev_state === dlpsc_pkg::DLPS_DEEP_WAIT && n < 11000) begin
      cyc(1);
      n++;
    end
    check("uninit", dlpsc_pkg::DLPS_UNINIT, dev_state);
    access(dlpsc_pkg::CMD_PRE, 3'h1);
    check("reinit", dlpsc_pkg::DLPS_IDLE, dev_state);
    check("mode_valid", 3'h1, 3'(mode_valid));
    $display("t_deep finished");
  endtask : t_deep
  task automatic t_stop();
    int n = 0;
    req_stop = 1'b1;
    cyc(20);
    repeat (16) begin
      cyc(1);
      n += (link.clk_t === 1'b0 && link.clk_gate === 1'b1);
    end
    check("parked", 3'h1, 3'(n == 16));
    check("dev_state", dlpsc_pkg::DLPS_IDLE, dev_state);
    req_stop = 1'b0;
    cyc(8);
    access(dlpsc_pkg::CMD_ACT, 3'h1);
    access(dlpsc_pkg::CMD_PRE, 3'h1);
    $display("t_stop finished");
  endtask : t_stop
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // reset spans four link periods; the link clock is frozen meanwhile, so the device's ref_clk stretcher carries it
  initial begin
    cyc(16);
    rst_n = 1'b1;
    cyc(40);
    check("reset", dlpsc_pkg::DLPS_IDLE, dev_state);
    t_access();
    t_pd(1'b0);
    t_pd(1'b1);
    t_deep();
    t_stop();
    test_done();
  end
  initial begin
    #600us;
    errors++;
    $display("MISMATCH watchdog expected end seen timeout");
    test_done();
  end
endmodule : tb_dram_low_power_state_control
`default_nettype wire
